// >>> hw/adc_setup_control.sv
// Overview of operation
// - Pin range code selects analog channels
// - Pin0 direction: 0 output, 1 input
// - Clock gate bit 5 enables converter
// - Bit 6 picks select or scan
// - Divider code sets conversion clock ratio
// - Timing mode sets 19 or 17 clocks
// - Go bit starts a conversion
// - Completion loads result, raises interrupt
// - Trigger field picks software or hardware
// - Mode bit, software trigger only: sequential 0, one-shot 1
//
// Design decisions made here: the register offsets and the plain strobed port.
`default_nettype none
module adc_setup_control #(
	parameter int RES_W = 10
) (
	// Clock and reset
	input  wire logic                    clk_in,
	input  wire logic                    sys_rst_in,
	// Register port
	input  wire adc_setup_pkg::reg_req_s req_in,
	output logic [7:0]                   rdata_out,
	// Analog side
	input  wire logic [RES_W-1:0]        sample_in,
	input  wire logic                    hw_trigger_in,
	output logic [3:0]                   analog_enable_out,
	output logic [3:0]                   sample_chan_out,
	output logic                         pin0_out_en_n_out,
	output logic                         converting_out,
	// Interrupt
	output logic                         irq_out
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0]       pin_cfg_r;
	logic [7:0]       port2_dir_r;
	logic [7:0]       clk_gate_r;
	logic [7:0]       mode_first_r;
	logic [7:0]       mode_sec_r;
	logic [7:0]       chan_sel_r;
	logic [RES_W-1:0] result_r;
	logic             stat_r;
	logic             irq_en_r;
	logic [6:0]       div_cnt_r;
	logic [4:0]       conv_cnt_r;
	logic [1:0]       hw_sync_r;
	logic             hw_prev_r;
	logic [RES_W-1:0] sample_s1_r;
	logic [RES_W-1:0] sample_s2_r;
	logic [1:0]       scan_idx_r;
	logic             wait_trig_r;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_CONV = 2'b10
	} conv_state_e;
	conv_state_e state_r;

	logic       gate_on;
	logic       go_bit;
	logic [6:0] div_ratio;
	logic       div_tick;
	logic [4:0] conv_len;
	logic       conv_done;
	logic       hw_edge;
	logic       sw_mode;
	logic       start_req;
	logic       go_write;
	logic       wr_mode;
	logic       go_clear;
	logic       gate_off_wr;

	// ----------------------------------------
	// Decoders
	// ----------------------------------------
	function automatic logic [6:0] div_of(input logic [2:0] code);
		unique case (code)
			3'h0: div_of = 7'h40;
			3'h1: div_of = 7'h20;
			3'h2: div_of = 7'h10;
			3'h3: div_of = 7'h08;
			3'h4: div_of = 7'h06;
			3'h5: div_of = 7'h05;
			3'h6: div_of = 7'h04;
			3'h7: div_of = 7'h02;
		endcase
	endfunction

	function automatic logic [3:0] range_of(input logic [2:0] code);
		case (code)
			adc_setup_pkg::PIN_RANGE_0_3:  range_of = 4'hF;
			adc_setup_pkg::PIN_RANGE_NONE: range_of = 4'h0;
			adc_setup_pkg::PIN_RANGE_0:    range_of = 4'h1;
			adc_setup_pkg::PIN_RANGE_0_1:  range_of = 4'h3;
			adc_setup_pkg::PIN_RANGE_0_2:  range_of = 4'h7;
			default:                       range_of = 4'h0;
		endcase
	endfunction

	// ----------------------------------------
	// Combinational control
	// ----------------------------------------
	assign gate_on   = clk_gate_r[adc_setup_pkg::POS_CONV_CLK_GATE];
	assign go_bit    = mode_first_r[adc_setup_pkg::POS_GO];
	assign div_ratio = div_of(mode_first_r[adc_setup_pkg::POS_DIV_LO +: 3]);
	assign div_tick  = (div_cnt_r == div_ratio - 7'h01);
	assign conv_len  = (mode_first_r[adc_setup_pkg::POS_TIM_LO +: 2] == 2'h1) ?
		adc_setup_pkg::CONV_CLKS_STD2 : adc_setup_pkg::CONV_CLKS_STD1;
	assign conv_done = (state_r == ST_CONV) && div_tick && (conv_cnt_r == conv_len - 5'h01);
	assign hw_edge   = hw_sync_r[1] && !hw_prev_r;
	assign sw_mode   = !mode_sec_r[adc_setup_pkg::POS_TRIG_LO + 1];
	assign wr_mode   = req_in.wr && (req_in.addr == adc_setup_pkg::OFS_MODE_FIRST);
	assign go_write  = wr_mode && req_in.wdata[adc_setup_pkg::POS_GO];
	// Gate write of 0 stops the sequencer on the same edge
	assign gate_off_wr = req_in.wr && (req_in.addr == adc_setup_pkg::OFS_CLK_GATE) &&
		!req_in.wdata[adc_setup_pkg::POS_CONV_CLK_GATE];
	assign start_req = gate_on && go_bit && mode_first_r[adc_setup_pkg::POS_CMP_ON] &&
		(sw_mode ? 1'b1 : (hw_edge || (wait_trig_r && hw_edge)));
	assign go_clear  = conv_done && mode_sec_r[adc_setup_pkg::POS_ONESHOT] &&
		sw_mode;

	assign analog_enable_out = range_of(pin_cfg_r[2:0]);
	assign pin0_out_en_n_out = port2_dir_r[adc_setup_pkg::POS_PIN0_DIR];
	assign converting_out    = (state_r == ST_CONV);
	assign irq_out           = stat_r && irq_en_r;

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			pin_cfg_r   <= adc_setup_pkg::RST_PIN_CFG;
			port2_dir_r <= adc_setup_pkg::RST_PORT2_DIR;
			clk_gate_r  <= adc_setup_pkg::RST_CLK_GATE;
			mode_sec_r  <= adc_setup_pkg::RST_MODE_SEC;
			chan_sel_r  <= 8'h00;
			irq_en_r    <= 1'b0;
		end else if (req_in.wr) begin
			unique case (req_in.addr)
				adc_setup_pkg::OFS_PIN_CFG:   pin_cfg_r <= {5'h00, req_in.wdata[2:0]};
				adc_setup_pkg::OFS_PORT2_DIR: port2_dir_r <= {4'hF, req_in.wdata[3:0]};
				adc_setup_pkg::OFS_CLK_GATE:  clk_gate_r <= req_in.wdata;
				adc_setup_pkg::OFS_MODE_SEC:  mode_sec_r <= {req_in.wdata[7:5], 5'h00};
				adc_setup_pkg::OFS_CHAN_SEL:  chan_sel_r <= {6'h00, req_in.wdata[1:0]};
				adc_setup_pkg::OFS_IRQ_EN:    irq_en_r <= req_in.wdata[0];
				default: ;
			endcase
		end
	end

	// Mode register, go bit cleared at one-shot end in software trigger mode only
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			mode_first_r <= adc_setup_pkg::RST_MODE_FIRST;
		end else if (wr_mode) begin
			mode_first_r <= req_in.wdata;
		end else if (go_clear) begin
			mode_first_r[adc_setup_pkg::POS_GO] <= 1'b0;
		end
	end

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			hw_sync_r   <= 2'h0;
			hw_prev_r   <= 1'b0;
			sample_s1_r <= '0;
			sample_s2_r <= '0;
		end else begin
			hw_sync_r   <= {hw_sync_r[0], hw_trigger_in};
			hw_prev_r   <= hw_sync_r[1];
			sample_s1_r <= sample_in;
			sample_s2_r <= sample_s1_r;
		end
	end

	// ----------------------------------------
	// Conversion sequencer
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			state_r    <= ST_IDLE;
			div_cnt_r  <= 7'h00;
			conv_cnt_r <= 5'h00;
			scan_idx_r <= 2'h0;
		end else if (!gate_on || gate_off_wr ||
			(wr_mode && !req_in.wdata[adc_setup_pkg::POS_GO])) begin
			state_r    <= ST_IDLE;
			div_cnt_r  <= 7'h00;
			conv_cnt_r <= 5'h00;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					div_cnt_r  <= 7'h00;
					conv_cnt_r <= 5'h00;
					if (start_req && !go_write) begin
						state_r <= ST_CONV;
					end
				end
				ST_CONV: begin
					div_cnt_r <= div_tick ? 7'h00 : div_cnt_r + 7'h01;
					if (div_tick) begin
						conv_cnt_r <= conv_done ? 5'h00 : conv_cnt_r + 5'h01;
					end
					if (conv_done) begin
						if (mode_first_r[adc_setup_pkg::POS_SCAN]) begin
							scan_idx_r <= scan_idx_r + 2'h1;
						end
						if (mode_sec_r[adc_setup_pkg::POS_ONESHOT] || !sw_mode) begin
							state_r <= ST_IDLE;
						end
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Wait-mode trigger latch
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			wait_trig_r <= 1'b0;
		end else begin
			wait_trig_r <= mode_sec_r[adc_setup_pkg::POS_TRIG_LO];
		end
	end

	assign sample_chan_out = mode_first_r[adc_setup_pkg::POS_SCAN] ?
		{2'h0, scan_idx_r} : {2'h0, chan_sel_r[1:0]};

	// ----------------------------------------
	// Result and interrupt
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			result_r <= '0;
		end else if (conv_done) begin
			result_r <= sample_s2_r;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			stat_r <= 1'b0;
		end else if (conv_done) begin
			stat_r <= 1'b1;
		end else if (req_in.wr && req_in.addr == adc_setup_pkg::OFS_IRQ_CLR && req_in.wdata[0]) begin
			stat_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rdata_out <= 8'h00;
		end else if (req_in.rd) begin
			case (req_in.addr)
				adc_setup_pkg::OFS_PIN_CFG:    rdata_out <= pin_cfg_r;
				adc_setup_pkg::OFS_PORT2_DIR:  rdata_out <= port2_dir_r;
				adc_setup_pkg::OFS_CLK_GATE:   rdata_out <= clk_gate_r;
				adc_setup_pkg::OFS_MODE_FIRST: rdata_out <= mode_first_r;
				adc_setup_pkg::OFS_MODE_SEC:   rdata_out <= mode_sec_r;
				adc_setup_pkg::OFS_RESULT_LO:  rdata_out <= result_r[7:0];
				adc_setup_pkg::OFS_RESULT_HI:  rdata_out <= {6'h00, result_r[RES_W-1:8]};
				adc_setup_pkg::OFS_IRQ_STAT:   rdata_out <= {7'h00, stat_r};
				adc_setup_pkg::OFS_IRQ_EN:     rdata_out <= {7'h00, irq_en_r};
				adc_setup_pkg::OFS_CHAN_SEL:   rdata_out <= chan_sel_r;
				default:                       rdata_out <= 8'h00;
			endcase
		end else begin
			rdata_out <= 8'h00;
		end
	end

endmodule
`default_nettype wire

// >>> hw/adc_setup_pkg.sv
`default_nettype none
package adc_setup_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [3:0] OFS_PIN_CFG    = 4'h0;
	localparam logic [3:0] OFS_PORT2_DIR  = 4'h1;
	localparam logic [3:0] OFS_CLK_GATE   = 4'h2;
	localparam logic [3:0] OFS_MODE_FIRST = 4'h3;
	localparam logic [3:0] OFS_MODE_SEC   = 4'h4;
	localparam logic [3:0] OFS_RESULT_LO  = 4'h5;
	localparam logic [3:0] OFS_RESULT_HI  = 4'h6;
	localparam logic [3:0] OFS_IRQ_STAT   = 4'h7;
	localparam logic [3:0] OFS_IRQ_EN     = 4'h8;
	localparam logic [3:0] OFS_IRQ_CLR    = 4'h9;
	localparam logic [3:0] OFS_CHAN_SEL   = 4'hA;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_PIN_CFG    = 8'h00;
	localparam logic [7:0] RST_PORT2_DIR  = 8'hFF;
	localparam logic [7:0] RST_CLK_GATE   = 8'h00;
	localparam logic [7:0] RST_MODE_FIRST = 8'h00;
	localparam logic [7:0] RST_MODE_SEC   = 8'h00;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int POS_CONV_CLK_GATE = 5;
	localparam int POS_GO            = 7;
	localparam int POS_SCAN          = 6;
	localparam int POS_DIV_LO        = 3;
	localparam int POS_TIM_LO        = 1;
	localparam int POS_CMP_ON        = 0;
	localparam int POS_TRIG_LO       = 6;
	localparam int POS_ONESHOT       = 5;
	localparam int POS_PIN0_DIR      = 0;

	// ----------------------------------------
	// Timing counts in conversion clocks, and pin range codes
	// ----------------------------------------
	localparam logic [4:0] CONV_CLKS_STD1 = 5'h13;
	localparam logic [4:0] CONV_CLKS_STD2 = 5'h11;
	localparam logic [2:0] PIN_RANGE_0_3  = 3'h0;
	localparam logic [2:0] PIN_RANGE_NONE = 3'h1;
	localparam logic [2:0] PIN_RANGE_0    = 3'h2;
	localparam logic [2:0] PIN_RANGE_0_1  = 3'h3;
	localparam logic [2:0] PIN_RANGE_0_2  = 3'h4;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_s;

endpackage
`default_nettype wire

// >>> test/adc_setup_assertions.sv
`default_nettype none
module adc_setup_assertions (
	// Clock and reset
	input wire logic                    clk_in,
	input wire logic                    sys_rst_in,
	// Watched ports
	input wire adc_setup_pkg::reg_req_s req_in,
	input wire logic [7:0]              rdata_out,
	input wire logic [9:0]              sample_in,
	input wire logic                    hw_trigger_in,
	input wire logic [3:0]              analog_enable_out,
	input wire logic [3:0]              sample_chan_out,
	input wire logic                    pin0_out_en_n_out,
	input wire logic                    converting_out,
	input wire logic                    irq_out
);
	localparam logic [55:0] DIVS = {7'h02, 7'h04, 7'h05, 7'h06, 7'h08, 7'h10, 7'h20, 7'h40};
	logic        gate_r, en_r, trig_r, one_r, scan_r, tim_r, go_w;
	logic [1:0]  chan_r;
	logic [2:0]  div_r;
	logic [3:0]  a;
	logic [7:0]  d;
	logic [10:0] cnt_r, lim;
	function automatic logic [3:0] dec_f(input logic [2:0] c);
		return (c == 3'h0) ? 4'hF : (c == 3'h1 || c > 3'h4) ? 4'h0 : 4'hF >> (3'h5 - c);
	endfunction
	assign a = req_in.addr;
	assign d = req_in.wdata;
	assign go_w = req_in.wr && a == 4'h3 && d[7] && d[0] && gate_r && !trig_r;
	assign lim = DIVS[div_r*7 +: 7] * (tim_r ? 5'h11 : 5'h13);
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			{gate_r, en_r, trig_r, one_r, scan_r, div_r, tim_r, chan_r} <= '0;
		end else if (req_in.wr) begin
			case (a)
				4'h2: gate_r <= d[5];
				4'h3: {scan_r, div_r, tim_r} <= {d[6:3], d[1]};
				4'h4: {trig_r, one_r} <= {d[7], d[5]};
				4'h8: en_r <= d[0];
				4'hA: chan_r <= d[1:0];
				default: ;
			endcase
		end
	end
	always_ff @(posedge clk_in) begin
		cnt_r <= (sys_rst_in || !converting_out) ? 11'h000 : cnt_r + 11'h001;
	end
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);
	a_pin_range_map: assert property (
		req_in.wr && a == 4'h0 |=> analog_enable_out == dec_f($past(d[2:0])))
		else $error("pin range decode wrong");
	a_pin0_dir: assert property (
		req_in.wr && a == 4'h1 |=> pin0_out_en_n_out == $past(d[0]))
		else $error("pin0 direction wrong");
	a_gate_idle: assert property (
		!gate_r |-> !converting_out) else $error("converting while clock gated");
	a_go_starts: assert property (
		go_w |-> ##[1:2] converting_out) else $error("start bit ignored");
	a_conv_length: assert property (
		$fell(converting_out) && !$past(req_in.wr) |-> cnt_r == lim)
		else $error("conversion length wrong");
	a_oneshot_once: assert property (
		converting_out && one_r |-> cnt_r < lim) else $error("one-shot overran");
	a_irq_on_end: assert property (
		$fell(converting_out) && en_r && !$past(req_in.wr) |-> ##[0:1] irq_out)
		else $error("no interrupt at end");
	a_irq_masked: assert property (
		!en_r && !$past(en_r) |-> !irq_out) else $error("masked interrupt seen");
	a_select_chan: assert property (
		converting_out && !scan_r |-> sample_chan_out == {2'h0, chan_r})
		else $error("select mode channel wrong");
	c_conv_end: cover property ($fell(converting_out));
	c_irq: cover property (irq_out);
	c_scan: cover property (converting_out && scan_r);
endmodule
`default_nettype wire

// >>> test/analog_pins_model.sv
`default_nettype none
module analog_pins_model (
	// Clock
	input  wire logic       clk_in,
	// Bench control
	input  wire logic [9:0] level_in,
	input  wire logic       trig_go_in,
	// Pins toward the block
	output logic [9:0]      sample_out,
	output logic            trig_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] hold_r = 3'h0;
	assign sample_out = level_in;
	assign trig_out = hold_r != 3'h0;
	always @(posedge clk_in) begin
		hold_r <= trig_go_in ? 3'h4 : hold_r - {2'h0, trig_out};
	end
endmodule
`default_nettype wire

// >>> test/tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	adc_setup_pkg::reg_req_s req;
	logic       clk_in, sys_rst_in, trig_go, rd_seen, hw_trig, pin_n, conv, irq;
	logic [7:0] rdata, exp_q[$];
	logic [9:0] sample, level;
	logic [3:0] ana_en, chan;
	int         miscompares, n_checks, cyc, k, seed;
	adc_setup_control i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .req_in(req),
		.rdata_out(rdata), .sample_in(sample), .hw_trigger_in(hw_trig),
		.analog_enable_out(ana_en), .sample_chan_out(chan), .pin0_out_en_n_out(pin_n),
		.converting_out(conv), .irq_out(irq));
	analog_pins_model i_pins (.clk_in(clk_in), .level_in(level), .trig_go_in(trig_go),
		.sample_out(sample), .trig_out(hw_trig));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic [3:0] a, input logic [7:0] d, input logic w);
		@(posedge clk_in);
		req <= '{a, d, w, !w};
		@(posedge clk_in);
		req <= '0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		bus(a, 8'h00, 1'b0);
	endtask
	task automatic run(input logic [7:0] m);
		bus(4'h3, m, 1'b1);
		repeat (3) @(posedge clk_in);
		for (k = 0; k < 1300 && conv !== 1'b0; k++) @(posedge clk_in);
		repeat (2) @(negedge clk_in);
	endtask
	task automatic results();
		$display("n_checks=%0d miscompares=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	always @(posedge clk_in) begin
		if (rd_seen) begin
			chk(rdata, exp_q.pop_front());
		end
		rd_seen <= req.rd;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			results();
		end
	end
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	initial begin
		req = '0;
		sys_rst_in = 1'b1;
		level = 10'h000;
		trig_go = 1'b0;
		rd_seen = 1'b0;
		seed = 32'hD237;
		repeat (10) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		for (k = 0; k < 8; k++) rd(4'(k), k == 1 ? 8'hFF : 8'h00);
		rd(4'hF, 8'h00);
		for (k = 7; k >= 0; k--) begin
			bus(4'h0, 8'(k), 1'b1);
			rd(4'h0, 8'(k));
		end
		level <= 10'($random(seed));
		@(posedge clk_in);
		bus(4'h1, {7'h78, level[0]}, 1'b1);
		rd(4'h1, {7'h78, level[0]});
		@(negedge clk_in);
		chk(pin_n, level[0]);
		bus(4'h8, 8'h01, 1'b1);
		bus(4'h4, 8'h20, 1'b1);
		run(8'h81);
		chk(conv, 1'b0);
		bus(4'h3, 8'h00, 1'b1);
		bus(4'h2, 8'h20, 1'b1);
		rd(4'h2, 8'h20);
		for (int i = 0; i < 16; i++) begin
			level <= 10'($random(seed));
			@(posedge clk_in);
			bus(4'hA, {6'h00, level[1:0]}, 1'b1);
			run({1'b1, i[3], i[2:0], 1'b0, i[3], 1'b1});
			chk(irq, 1'b1);
			rd(4'h5, level[7:0]);
			rd(4'h6, {6'h00, level[9:8]});
			rd(4'h7, 8'h01);
			bus(4'h9, 8'h01, 1'b1);
			repeat (2) @(negedge clk_in);
			chk(irq, 1'b0);
		end
		run(8'hB9);
		bus(4'h8, 8'h00, 1'b1);
		repeat (2) @(negedge clk_in);
		chk(irq, 1'b0);
		bus(4'h8, 8'h01, 1'b1);
		repeat (2) @(negedge clk_in);
		chk(irq, 1'b1);
		bus(4'h4, 8'h00, 1'b1);
		bus(4'h3, 8'hB9, 1'b1);
		repeat (100) @(negedge clk_in);
		chk(conv, 1'b1);
		bus(4'h2, 8'h00, 1'b1);
		@(negedge clk_in);
		chk(conv, 1'b0);
		bus(4'h3, 8'h00, 1'b1);
		bus(4'h2, 8'h20, 1'b1);
		bus(4'h4, 8'hA0, 1'b1);
		bus(4'h3, 8'hB9, 1'b1);
		repeat (6) @(negedge clk_in);
		chk(conv, 1'b0);
		trig_go <= 1'b1;
		@(posedge clk_in);
		trig_go <= 1'b0;
		repeat (8) @(negedge clk_in);
		chk(conv, 1'b1);
		results();
	end
endmodule
bind adc_setup_control adc_setup_assertions i_chk (.clk_in(clk_in),
	.sys_rst_in(sys_rst_in), .req_in(req_in), .rdata_out(rdata_out),
	.sample_in(sample_in), .hw_trigger_in(hw_trigger_in),
	.analog_enable_out(analog_enable_out), .sample_chan_out(sample_chan_out),
	.pin0_out_en_n_out(pin0_out_en_n_out), .converting_out(converting_out),
	.irq_out(irq_out));
`default_nettype wire
